// ### pkg/mfgp_defines.vh
// Purpose: Constants of the multi-function GPIO port block
// Assumes: 40 MHz core clock
// Notes:   Definitions only
`ifndef MFGP_DEFINES_VH
`define MFGP_DEFINES_VH

// Clock rates in kHz
`define MFGP_CLK_KHZ        40000
`define MFGP_DIVCLK_KHZ     2560
// Accumulator step for half-period toggles of the divided clock
`define MFGP_DIVCLK_STEP    (2 * `MFGP_DIVCLK_KHZ)

// Register kind codes on reg_kind
`define MFGP_KIND_CTRL      2'h0
`define MFGP_KIND_DATA      2'h1
`define MFGP_KIND_SET       2'h2
`define MFGP_KIND_CLR       2'h3

// Port numbers
`define MFGP_PORT_NUM       3

// Fields of port_dir_data: input levels, output data, direction
`define MFGP_DAT_IN_LSB     0
`define MFGP_DAT_OUT_LSB    16
`define MFGP_DAT_DIR_LSB    24

// Control register: alternate select of port bit b is bit 4*b
`define MFGP_ALT_STRIDE     4
`define MFGP_CTRL_DIVCLK    16
`define MFGP_CTRL_HV0_EN    20
`define MFGP_CTRL_HV1_EN    24

// Reset values
`define MFGP_CTRL_RST       32'h00000000
`define MFGP_FIELD_RST      8'h00

// Implemented bits per port field
`define MFGP_MASK_P0        8'h7F
`define MFGP_MASK_P1        8'h03
`define MFGP_MASK_P2        8'h33

`endif

// ### hdl/mfgp_irq_sync.v
// Purpose: Two-stage synchroniser for level interrupt requests
// Assumes: Stages advance on the divided core clock enable
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps
`include "mfgp_defines.vh"

module mfgp_irq_sync #(
    parameter W = 4
) (
    // Clock and reset
    input  wire         clk,
    input  wire         rst,
    // Divided clock enable
    input  wire         tick,
    // Raw and synchronised levels
    input  wire [W-1:0] lvl_in,
    output wire [W-1:0] lvl_out
);

    genvar i;
    generate
        for (i = 0; i < W; i = i + 1)
        begin : g_bit
            reg meta_reg;   // First stage, read only by sync_reg
            reg sync_reg;   // Second stage, safe to use
            // Level pipeline stepped by divided clock
            always @(posedge clk)
            begin
                if (rst)
                begin
                    meta_reg <= 1'b0;
                    sync_reg <= 1'b0;
                end
                else if (tick)
                begin
                    meta_reg <= lvl_in[i];
                    sync_reg <= meta_reg;
                end
            end
            assign lvl_out[i] = sync_reg;
        end
    endgenerate

endmodule

// ### hdl/mfgp_top.v
// Purpose: Nine-pin multi-function GPIO with three ports
// Assumes: Inputs synchronous to clk; register access via plain strobe port
// Notes:   Divided clock output has one-cycle jitter at 40 MHz
// Functional notes
// - Nine two-way pins, plain GPIO after reset
// - Ports of 5, 2 and 2 pins
// - Pins 0,5,7,8 are active-high level interrupts
// - Each port: control, data, set, clear registers
// - Pin levels held during power-down
// - Pin 0: port zero bit 0, SPI select
// - Pins 1-3: SPI clock, MISO, MOSI
// - Pin 4 alternate: continuous 2.56MHz clock
// - Port zero bits 5,6 form high-voltage link
// - Pins 7,8: port two, LIN test paths
// - Port two bits 4,5: diagnostic readback, write
// - Control bit 16 selects clock output
`timescale 1ns/1ps
`include "mfgp_defines.vh"

module mfgp_top (
    // Clock and reset
    input  wire        clk,
    input  wire        rst,
    // Divided core clock enable and power state
    input  wire        cd_tick,
    input  wire        power_down,
    // Register write/read port
    input  wire        reg_wr,
    input  wire [1:0]  reg_port,
    input  wire [1:0]  reg_kind,
    input  wire [31:0] reg_wdata,
    output reg  [31:0] reg_rdata,
    // External pins
    input  wire [8:0]  pin_in,
    output reg  [8:0]  pin_out,
    output reg  [8:0]  pin_oe_n,
    // Alternate function peripherals
    input  wire [8:0]  alt_out,
    input  wire [8:0]  alt_oe_n,
    output reg  [8:0]  alt_in,
    // High-voltage two-wire link
    input  wire [1:0]  hv_link_in,
    output reg  [1:0]  hv_link_out,
    output reg  [1:0]  hv_link_oe_n,
    // LIN pin diagnostics
    input  wire        lin_diag_readback,
    output reg         lin_diag_drive,
    output reg         lin_diag_oe_n,
    // Level interrupt requests
    output reg         ext_int_0,
    output reg         ext_int_1,
    output reg         ext_int_4,
    output reg         ext_int_5
);

    // Pin to port map, two bits each, pin 8 first
    localparam [17:0] PIN_PORT = {2'h2, 2'h2, 2'h1, 2'h1, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0};
    localparam [26:0] PIN_BIT  = {3'h1, 3'h0, 3'h1, 3'h0, 3'h4, 3'h3, 3'h2, 3'h1, 3'h0};
    // Full-width copies, then cut to the 16-bit accumulator on purpose
    localparam [31:0] ACC_MOD_W  = `MFGP_CLK_KHZ;
    localparam [31:0] ACC_STEP_W = `MFGP_DIVCLK_STEP;
    localparam [15:0] ACC_MOD    = ACC_MOD_W[15:0];
    localparam [15:0] ACC_STEP   = ACC_STEP_W[15:0];

    // Port registers, one entry per port
    reg  [31:0] ctrl_reg [0:2];   // port_function_ctrl
    reg  [7:0]  dir_reg  [0:2];   // Direction, 1 drives
    reg  [7:0]  out_reg  [0:2];   // Output data
    reg  [7:0]  in_reg   [0:2];   // Sampled input levels
    // Implemented bits, port 2 in the top byte; a net holds them from time zero
    wire [23:0] mask_all = {`MFGP_MASK_P2, `MFGP_MASK_P1, `MFGP_MASK_P0};
    // Divided clock generator
    reg  [15:0] acc_reg;
    reg  [15:0] acc_next;
    reg         divclk_reg;
    // Pin drive candidates
    reg  [8:0]  drv_out;
    reg  [8:0]  drv_oe_n;
    // Synchronised interrupt levels
    wire [3:0]  irq_sync;
    integer     k;
    integer     p;
    integer     m;            // Loop index of the input sampler only

    // Register writes; reset leaves every pin GPIO input
    always @(posedge clk)
    begin
        if (rst)
        begin
            for (k = 0; k < `MFGP_PORT_NUM; k = k + 1)
            begin
                ctrl_reg[k] <= `MFGP_CTRL_RST;
                dir_reg[k]  <= `MFGP_FIELD_RST;
                out_reg[k]  <= `MFGP_FIELD_RST;
            end
        end
        else if (reg_wr && (reg_port < 2'h3))
        begin
            case (reg_kind)
                // Function select bits
                `MFGP_KIND_CTRL:
                begin
                    ctrl_reg[reg_port] <= reg_wdata;
                end
                // Direction and data together
                `MFGP_KIND_DATA:
                begin
                    dir_reg[reg_port] <= reg_wdata[`MFGP_DAT_DIR_LSB +: 8] & mask_all[8*reg_port +: 8];
                    out_reg[reg_port] <= reg_wdata[`MFGP_DAT_OUT_LSB +: 8] & mask_all[8*reg_port +: 8];
                end
                // Ones drive high, zeros untouched
                `MFGP_KIND_SET:
                begin
                    out_reg[reg_port] <= out_reg[reg_port]
                                       | (reg_wdata[`MFGP_DAT_OUT_LSB +: 8] & mask_all[8*reg_port +: 8]);
                end
                // Ones drive low, zeros untouched
                `MFGP_KIND_CLR:
                begin
                    out_reg[reg_port] <= out_reg[reg_port]
                                       & ~reg_wdata[`MFGP_DAT_OUT_LSB +: 8];
                end
                default:
                begin
                    out_reg[reg_port] <= out_reg[reg_port];
                end
            endcase
        end
    end

    // Input sampling into each port's level field
    always @(posedge clk)
    begin
        if (rst)
        begin
            for (m = 0; m < `MFGP_PORT_NUM; m = m + 1)
            begin
                in_reg[m] <= `MFGP_FIELD_RST;
            end
        end
        else
        begin
            in_reg[0] <= {1'b0, hv_link_in, pin_in[4:0]};
            in_reg[1] <= {6'h00, pin_in[6:5]};
            in_reg[2] <= {2'h0, 1'b0, lin_diag_readback, 2'h0, pin_in[8:7]};
        end
    end

    // Read path, one cycle after the request; set/clear read zero
    always @(posedge clk)
    begin
        if (rst)
        begin
            reg_rdata <= 32'h00000000;
        end
        else if (reg_port == 2'h3)
        begin
            reg_rdata <= 32'h00000000;  // Unmapped port
        end
        else if (reg_kind == `MFGP_KIND_CTRL)
        begin
            reg_rdata <= ctrl_reg[reg_port];
        end
        else if (reg_kind == `MFGP_KIND_DATA)
        begin
            reg_rdata <= {dir_reg[reg_port], out_reg[reg_port], 8'h00, in_reg[reg_port]};
        end
        else
        begin
            reg_rdata <= 32'h00000000;
        end
    end

    // Accumulator divider: average rate is exact, edges jitter by one cycle
    always @*
    begin
        acc_next = acc_reg + ACC_STEP;
        if (acc_next >= ACC_MOD)
        begin
            acc_next = acc_next - ACC_MOD;
        end
    end

    // Free-running clock toggle, independent of select bit
    always @(posedge clk)
    begin
        if (rst)
        begin
            acc_reg    <= 16'h0000;
            divclk_reg <= 1'b0;
        end
        else
        begin
            acc_reg <= acc_next;
            if (acc_reg + ACC_STEP >= ACC_MOD)
            begin
                divclk_reg <= ~divclk_reg;
            end
        end
    end

    // Per-pin function mux: alternate or GPIO
    always @*
    begin
        drv_out  = 9'h000;
        drv_oe_n = 9'h1FF;
        for (p = 0; p < 9; p = p + 1)
        begin
            if (ctrl_reg[PIN_PORT[2*p +: 2]][`MFGP_ALT_STRIDE * PIN_BIT[3*p +: 3]])
            begin
                if (p == 4)
                begin
                    drv_out[p]  = divclk_reg;
                    drv_oe_n[p] = 1'b0;
                end
                else
                begin
                    drv_out[p]  = alt_out[p];
                    drv_oe_n[p] = alt_oe_n[p];
                end
            end
            else
            begin
                drv_out[p]  = out_reg[PIN_PORT[2*p +: 2]][PIN_BIT[3*p +: 3]];
                drv_oe_n[p] = ~dir_reg[PIN_PORT[2*p +: 2]][PIN_BIT[3*p +: 3]];
            end
        end
    end

    // Pin and internal-link drivers, frozen in power-down
    always @(posedge clk)
    begin
        if (rst)
        begin
            pin_out        <= 9'h000;
            pin_oe_n       <= 9'h1FF;
            alt_in         <= 9'h000;
            hv_link_out    <= 2'h0;
            hv_link_oe_n   <= 2'h3;
            lin_diag_drive <= 1'b0;
            lin_diag_oe_n  <= 1'b1;
        end
        else if (!power_down)
        begin
            pin_out  <= drv_out;
            pin_oe_n <= drv_oe_n;
            alt_in   <= pin_in;
            // Link bits only drive once software enabled them
            hv_link_out     <= out_reg[0][6:5];
            hv_link_oe_n[0] <= ~(ctrl_reg[0][`MFGP_CTRL_HV0_EN] & dir_reg[0][5]);
            hv_link_oe_n[1] <= ~(ctrl_reg[0][`MFGP_CTRL_HV1_EN] & dir_reg[0][6]);
            // Diagnostic write path of the LIN pin
            lin_diag_drive <= out_reg[2][5];
            lin_diag_oe_n  <= ~dir_reg[2][5];
        end
    end

    // Interrupt pins through divided-clock synchroniser
    mfgp_irq_sync #(
        .W (4)
    ) u_irq_sync (
        .clk     (clk),
        .rst     (rst),
        .tick    (cd_tick),
        .lvl_in  ({pin_in[8], pin_in[7], pin_in[5], pin_in[0]}),
        .lvl_out (irq_sync)
    );

    // Unlatched level requests; source must hold them
    always @(posedge clk)
    begin
        if (rst)
        begin
            ext_int_0 <= 1'b0;
            ext_int_1 <= 1'b0;
            ext_int_4 <= 1'b0;
            ext_int_5 <= 1'b0;
        end
        else
        begin
            ext_int_0 <= irq_sync[0];
            ext_int_1 <= irq_sync[1];
            ext_int_4 <= irq_sync[2];
            ext_int_5 <= irq_sync[3];
        end
    end

endmodule

// ### tb/mfgp_board.sv
// Purpose: Board and link-side model around the GPIO block
// Assumes: Every GPIO pin has a pull-up
// Notes:   Device drive wins over a board source
`timescale 1ns/1ps

module mfgp_board (
    // Clock
    input  wire       clk,
    // Device drives
    input  wire [8:0] pin_out,
    input  wire [8:0] pin_oe_n,
    input  wire [1:0] hv_link_out,
    input  wire [1:0] hv_link_oe_n,
    input  wire       lin_diag_drive,
    input  wire       lin_diag_oe_n,
    // Board sources set by the bench
    input  wire [8:0] ext_en,
    input  wire [8:0] ext_val,
    // Levels seen by the device
    output wire [8:0] pin_in,
    output wire [1:0] hv_link_in,
    output wire       lin_diag_readback
);
    reg [1:0] hv_last_reg = 2'h0; // Last level driven on the link

    // Pin level: device, then board source, else pull-up
    assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ((ext_en & ext_val) | ~ext_en));

    // Link wires echo the drive; released wires show the inverse of the last value
    always @(posedge clk)
    begin
        hv_last_reg <= (~hv_link_oe_n & hv_link_out) | (hv_link_oe_n & hv_last_reg);
    end
    assign hv_link_in = (~hv_link_oe_n & hv_link_out) | (hv_link_oe_n & ~hv_last_reg);

    // Diagnostic drive loops back through the pulled-up line
    assign lin_diag_readback = lin_diag_oe_n | lin_diag_drive;
endmodule

// ### tb/mfgp_top_asserts.sv
// Purpose: Port-level checker of the GPIO block
// Assumes: Single clock, synchronous active-high reset
// Notes:   Bound into every mfgp_top
`timescale 1ns/1ps

module mfgp_chk (
    // Clock and control
    input wire        clk,
    input wire        rst,
    input wire        cd_tick,
    input wire        power_down,
    // Register port
    input wire        reg_wr,
    input wire [1:0]  reg_port,
    input wire [1:0]  reg_kind,
    input wire [31:0] reg_wdata,
    input wire [31:0] reg_rdata,
    // Outputs watched
    input wire [8:0]  pin_out,
    input wire [8:0]  pin_oe_n,
    input wire [8:0]  alt_in,
    input wire [1:0]  hv_link_oe_n,
    input wire        lin_diag_oe_n,
    input wire        ext_int_0,
    input wire        ext_int_1,
    input wire        ext_int_4,
    input wire        ext_int_5
);
    reg       div_sel_reg; // Mirror of the clock-out select
    reg [3:0] run_cnt_reg; // Cycles without a clock-out edge
    reg       last_out_reg; // Clock-out level one cycle back

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // Track the clock-out select from port zero control writes
    always @(posedge clk)
    begin
        if (rst)
            div_sel_reg <= 1'b0;
        else if (reg_wr && reg_port == 2'h0 && reg_kind == 2'h0)
            div_sel_reg <= reg_wdata[16];
    end

    // Saturating run length; a stuck clock output is caught quickly
    always @(posedge clk)
    begin
        last_out_reg <= pin_out[4];
        if (rst || !div_sel_reg || power_down || pin_out[4] != last_out_reg)
            run_cnt_reg <= 4'h0;
        else
            run_cnt_reg <= run_cnt_reg + {3'h0, run_cnt_reg != 4'hF};
    end

    a_reset_idle: assert property (disable iff (1'b0) rst |=> pin_oe_n == 9'h1FF && pin_out == 9'h000 &&
        hv_link_oe_n == 2'h3 && lin_diag_oe_n && !{ext_int_0, ext_int_1, ext_int_4, ext_int_5})
        else $error("outputs not idle after reset");
    a_hold_power: assert property (power_down |=> $stable(pin_out) && $stable(pin_oe_n) && $stable(alt_in))
        else $error("pin outputs moved in power-down");
    a_int_on_tick: assert property (!$past(cd_tick) && !$past(cd_tick, 2) |->
        $stable({ext_int_0, ext_int_1, ext_int_4, ext_int_5}))
        else $error("interrupt level changed without a divided tick");
    a_clk_out_drive: assert property (div_sel_reg && !power_down |=> !pin_oe_n[4])
        else $error("clock output pin not driven");
    a_clk_out_runs: assert property (run_cnt_reg < 4'hC)
        else $error("clock output stalled");
    a_data_readback: assert property (reg_wr && reg_kind == 2'h1 && reg_port == 2'h1 ##1
        reg_kind == 2'h1 && reg_port == 2'h1 |=> reg_rdata[31:16] == ($past(reg_wdata[31:16], 2) & 16'h0303))
        else $error("port one data readback wrong");
    a_unmapped_zero: assert property (reg_port == 2'h3 |=> reg_rdata == 32'h00000000)
        else $error("unmapped port read not zero");
    a_setclr_zero: assert property (reg_kind[1] |=> reg_rdata == 32'h00000000)
        else $error("set or clear register read not zero");

    c_clk_out: cover property (div_sel_reg && !pin_oe_n[4]);
    c_int_rise: cover property ($rose(ext_int_1));
    c_pd_write: cover property (power_down ##1 reg_wr);
endmodule

bind mfgp_top mfgp_chk u_mfgp_chk (.clk, .rst, .cd_tick, .power_down, .reg_wr, .reg_port, .reg_kind, .reg_wdata,
    .reg_rdata, .pin_out, .pin_oe_n, .alt_in, .hv_link_oe_n, .lin_diag_oe_n, .ext_int_0, .ext_int_1, .ext_int_4,
    .ext_int_5);

// ### tb/mfgp_top_tb.sv
// Purpose: Self-checking bench of the GPIO block
// Assumes: Divided core clock tick every 4 cycles
// Notes:   Board model supplies pull-ups and interrupt sources
`timescale 1ns/1ps
`include "mfgp_defines.vh"
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin fail_count++; \
    $display("wrong value at %0t: got %h expected %h", $time, a, e); end end

module mfgp_top_tb;
    // Stimulus
    reg        clk = 1'b0, rst = 1'b1, cd_tick = 1'b0, power_down = 1'b0, reg_wr = 1'b0;
    reg [1:0]  reg_port = 2'h0, reg_kind = 2'h0, tick_cnt = 2'h0;
    reg [31:0] reg_wdata = 32'h0, rv;
    reg [8:0]  alt_out = 9'h000, alt_oe_n = 9'h1FF, ext_val = 9'h000;
    // Design outputs and board levels
    wire [31:0] reg_rdata;
    wire [8:0]  pin_in, pin_out, pin_oe_n, alt_in;
    wire [1:0]  hv_link_in, hv_link_out, hv_link_oe_n;
    wire        lin_diag_readback, lin_diag_drive, lin_diag_oe_n, ext_int_0, ext_int_1, ext_int_4, ext_int_5;
    wire [3:0]  iv = {ext_int_5, ext_int_4, ext_int_1, ext_int_0};
    integer     fail_count = 0, tests_run = 0, p, b, n;

    mfgp_top u_mfgp_top (.clk(clk), .rst(rst), .cd_tick(cd_tick), .power_down(power_down), .reg_wr(reg_wr),
        .reg_port(reg_port), .reg_kind(reg_kind), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe_n(pin_oe_n), .alt_out(alt_out), .alt_oe_n(alt_oe_n), .alt_in(alt_in),
        .hv_link_in(hv_link_in), .hv_link_out(hv_link_out), .hv_link_oe_n(hv_link_oe_n),
        .lin_diag_readback(lin_diag_readback), .lin_diag_drive(lin_diag_drive), .lin_diag_oe_n(lin_diag_oe_n),
        .ext_int_0(ext_int_0), .ext_int_1(ext_int_1), .ext_int_4(ext_int_4), .ext_int_5(ext_int_5));
    // Interrupt pins 0,5,7,8 have board sources
    mfgp_board u_mfgp_board (.clk(clk), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .hv_link_out(hv_link_out),
        .hv_link_oe_n(hv_link_oe_n), .lin_diag_drive(lin_diag_drive), .lin_diag_oe_n(lin_diag_oe_n),
        .ext_en(9'h1A1), .ext_val(ext_val), .pin_in(pin_in), .hv_link_in(hv_link_in),
        .lin_diag_readback(lin_diag_readback));

    // 40 MHz clock and divided tick
    always #12.5 clk = ~clk;
    always @(posedge clk)
    begin
        tick_cnt <= tick_cnt + 2'h1;
        cd_tick  <= (tick_cnt == 2'h3);
    end

    // Write one register; returns once pins have followed
    task wr(input [1:0] wp, input [1:0] k, input [31:0] d);
    begin
        @(posedge clk);
        reg_wr <= 1'b1; reg_port <= wp; reg_kind <= k; reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
        #1;
    end
    endtask

    // Read one register into rv
    task rd(input [1:0] rp, input [1:0] k);
    begin
        @(posedge clk);
        reg_port <= rp; reg_kind <= k;
        @(posedge clk);
        #1 rv = reg_rdata;
    end
    endtask

    // Bounded wait for an interrupt pattern; a miss ends the run
    task wait_iv(input [3:0] e);
    begin
        n = 0;
        while (iv !== e && n < 20)
        begin
            @(posedge clk);
            #1 n = n + 1;
        end
        `CHK(iv, e)
        if (iv !== e)
            end_sim;
    end
    endtask

    task end_sim;
    begin
        $display("comparisons %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    end
    endtask

    // Main sequence
    initial
    begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1 `CHK(pin_oe_n, 9'h1FF)
        for (p = 0; p < 3; p++)
        begin
            rd(p, `MFGP_KIND_CTRL);
            `CHK(rv, 32'h00000000)
        end
        // Each source held high for several ticks, then dropped
        for (p = 0; p < 4; p++)
        begin
            @(posedge clk);
            ext_val <= 9'h001 << ((p == 0) ? 0 : (p == 1) ? 5 : p + 5);
            wait_iv(4'h1 << p);
            @(posedge clk);
            ext_val <= 9'h000;
            wait_iv(4'h0);
        end
        // Data, set and clear on every port
        for (p = 0; p < 3; p++)
        begin
            b = (p == 0) ? 0 : (p == 1) ? 5 : 7;
            wr(p, `MFGP_KIND_DATA, 32'h03000000);
            wr(p, `MFGP_KIND_SET, 32'h00030000);
            wr(p, `MFGP_KIND_CLR, 32'h00010000);
            `CHK(pin_out[b +: 2], 2'b10)
            `CHK(pin_oe_n[b +: 2], 2'b00)
            rd(p, `MFGP_KIND_DATA);
            `CHK(rv[31:16], 16'h0302)
        end
        wr(3, `MFGP_KIND_DATA, 32'hFFFF0000);
        rd(3, `MFGP_KIND_DATA);
        `CHK(rv, 32'h00000000)
        // SPI and LIN test alternates
        @(posedge clk);
        alt_out <= 9'h10A;
        alt_oe_n <= 9'h070;
        wr(0, `MFGP_KIND_CTRL, 32'h00001111);
        wr(2, `MFGP_KIND_CTRL, 32'h00000011);
        `CHK({pin_out[8:7], pin_out[3:0]}, 6'h2A)
        `CHK({pin_oe_n[8:7], pin_oe_n[3:0]}, 6'h00)
        `CHK(alt_in[3:0], 4'hA)
        // Divided clock: 625 cycles hold 40 periods
        wr(0, `MFGP_KIND_CTRL, 32'h00010000);
        `CHK(pin_oe_n[4], 1'b0)
        b = 0;
        for (n = 0; n < 625; n++)
        begin
            p = pin_out[4];
            @(posedge clk);
            #1 b = b + (pin_out[4] !== p);
        end
        `CHK(b >= 79 && b <= 81, 1'b1)
        wr(0, `MFGP_KIND_CTRL, 32'h00000000);
        `CHK(pin_oe_n[4], 1'b1)
        // Link drive stays off until enabled
        wr(0, `MFGP_KIND_DATA, 32'h60600000);
        `CHK(hv_link_oe_n, 2'h3)
        wr(0, `MFGP_KIND_CTRL, 32'h01100000);
        `CHK(hv_link_oe_n, 2'h0)
        `CHK(hv_link_out, 2'h3)
        rd(0, `MFGP_KIND_DATA);
        `CHK(rv[6:5], 2'b11)
        // Diagnostic write and read-back
        wr(2, `MFGP_KIND_DATA, 32'h20200000);
        `CHK({lin_diag_oe_n, lin_diag_drive}, 2'b01)
        rd(2, `MFGP_KIND_DATA);
        `CHK(rv[4], 1'b1)
        wr(2, `MFGP_KIND_CLR, 32'h00200000);
        rd(2, `MFGP_KIND_DATA);
        `CHK(rv[4], 1'b0)
        // Power-down holds pin levels
        @(posedge clk);
        power_down <= 1'b1;
        wr(1, `MFGP_KIND_SET, 32'h00010000);
        `CHK(pin_out[6:5], 2'b10)
        @(posedge clk);
        power_down <= 1'b0;
        repeat (2) @(posedge clk);
        #1 `CHK(pin_out[6:5], 2'b11)
        end_sim;
    end
endmodule
